//--- bflp_pkg.sv
// constants, types and carriers for the boot flash lock protection block
package bflp_pkg;

  // ---------------------------------------------------------------
  // flash geometry and section boundaries (word addresses)
  // ---------------------------------------------------------------
  localparam logic [14:0] BOOT_START_512 = 15'h7E00;
  localparam logic [14:0] BOOT_START_1K = 15'h7C00;
  localparam logic [14:0] BOOT_START_2K = 15'h7800;
  localparam logic [14:0] BOOT_START_4K = 15'h7000;
  localparam logic [14:0] APP_END_2K = 15'h77FF;
  localparam logic [14:0] APP_END_4K = 15'h6FFF;
  localparam logic [14:0] FLASH_END = 15'h7FFF;
  localparam logic [14:0] RWW_END = 15'h6FFF;
  localparam logic [14:0] BLOCKED_DURING_WRITE_REGION_START = 15'h7000;
  localparam logic [6:0] PAGE_BASE = 7'h00;
  localparam logic [1:0] BOOTSZ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // lock byte layout, 1 = unprogrammed
  // ---------------------------------------------------------------
  localparam int LK_BOOT_HI = 5;
  localparam int LK_BOOT_LO = 4;
  localparam int LK_APP_HI = 3;
  localparam int LK_APP_LO = 2;
  localparam int LK_MEM_HI = 1;
  localparam int LK_MEM_LO = 0;
  localparam int LK_BITS = 6;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  localparam logic [1:0] LOCK_PAD = 2'h3;
  localparam logic [5:0] SPM_LOCK_MASK = 6'h3C;

  // ---------------------------------------------------------------
  // register map, byte addresses on the wishbone port
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LOCK = 8'h00;
  localparam logic [7:0] OFS_FUSE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam int CTRL_ERASE = 0;
  localparam int CTRL_CLR_ST = 1;
  localparam int CTRL_CLR_LD = 2;

  // ---------------------------------------------------------------
  // write timing from the calibrated rc oscillator tick
  // ---------------------------------------------------------------
  localparam int RC_KHZ = 1000;
  localparam int WR_MIN_US = 3700;
  localparam int WR_MAX_US = 4500;
  localparam int WR_MIN_TICKS = (WR_MIN_US * RC_KHZ + 999) / 1000;
  localparam int WR_MAX_TICKS = (WR_MAX_US * RC_KHZ) / 1000;
  localparam logic [12:0] WR_TICKS_DEF = 13'((WR_MIN_TICKS + WR_MAX_TICKS) / 2);

  // ---------------------------------------------------------------
  // commands, states and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_FILL = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_LOCK = 2'b11
  } bflp_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } bflp_state_t;

  typedef struct packed {
    bflp_op_t op;
    logic [15:0] z;
    logic [7:0] data;
  } bflp_store_t;

endpackage : bflp_pkg

//--- bflp_top.sv
// boot flash lock protection: section split, lock modes and write timing
//
// Contract
// [R1] flash writes last 3.7 to 4.5 ms
// [R2] size 11: boot 0x7E00-0x7FFF, vector 0x7E00
// [R3] size 10: boot from 0x7C00, vector 0x7C00
// [R4] size 01: boot from 0x7800, app ends 0x77FF
// [R5] size 00: boot from 0x7000, app ends 0x6FFF
// [R6] readable region 0x0000-0x6FFF, blocked 0x7000-0x7FFF
// [R7] page number from pointer bits 15..8
// [R8] word from bits 7..1, zero on page write
// [R9] bit 0 zero on stores, byte select on loads
// [R10] six lock bits, only erase restores ones; srst also loads all six bits to one
// [R11] lock byte layout, upper bits one
// [R12] memory mode 2 stops external programming, fuses
// [R13] memory mode 3 also stops external verification
// [R14] app mode 2 blocks stores to app
// [R15] app mode 3 blocks stores, boot loads
// [R16] app mode 4 blocks boot-code loads of app
// [R17] app modes 3,4 mute app-side interrupts
// [R18] boot mode 2 blocks stores to boot
// [R19] boot mode 3 blocks stores, app loads
// [R20] boot mode 4 blocks app-code loads of boot
// [R21] boot modes 3,4 mute boot-side interrupts
// [R22] programmer sets fuses before lock bits
// [R23] classify addresses against boot boundary
module bflp_top #(
  parameter logic [12:0] WR_TICKS = bflp_pkg::WR_TICKS_DEF
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // calibrated rc oscillator tick
  input wire logic rc_tick,
  // cpu self-program stores
  input wire logic store_req,
  input wire bflp_pkg::bflp_store_t store_cmd,
  output logic store_done_o,
  output logic store_deny_o,
  output logic [7:0] page_num_o,
  output logic [6:0] word_idx_o,
  // cpu program memory loads
  input wire logic load_req,
  input wire logic [15:0] load_z,
  output logic load_ok_o,
  output logic load_deny_o,
  output logic [14:0] load_word_o,
  output logic load_byte_hi_o,
  // execution context
  input wire logic [14:0] fetch_pc,
  input wire logic ivec_in_boot,
  output logic irq_suppress_o,
  output logic [14:0] boot_vector_o,
  // write progress
  output logic busy_o,
  output logic rww_busy_o,
  output logic cpu_halt_o,
  // external programming gates
  output logic ext_prog_en_o,
  output logic ext_verify_en_o,
  output logic fuse_wr_en_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bflp_pkg::bflp_state_t state_reg;
  logic [5:0] lock_reg;
  logic [1:0] bootsz_reg;
  logic [12:0] tick_reg;
  logic [5:0] spm_mask_reg;
  logic st_denied_reg;
  logic ld_denied_reg;
  // lock fields, 0 = programmed
  wire boot_hi = lock_reg[bflp_pkg::LK_BOOT_HI];
  wire boot_lo = lock_reg[bflp_pkg::LK_BOOT_LO];
  wire app_hi = lock_reg[bflp_pkg::LK_APP_HI];
  wire app_lo = lock_reg[bflp_pkg::LK_APP_LO];
  wire mem_hi = lock_reg[bflp_pkg::LK_MEM_HI];
  wire mem_lo = lock_reg[bflp_pkg::LK_MEM_LO];
  wire [7:0] lock_byte = {bflp_pkg::LOCK_PAD, lock_reg}; // R11
  // boot boundary from the size select
  wire [14:0] boundary =
    (bootsz_reg == 2'h3) ? bflp_pkg::BOOT_START_512 : // R2
    (bootsz_reg == 2'h2) ? bflp_pkg::BOOT_START_1K : // R3
    (bootsz_reg == 2'h1) ? bflp_pkg::BOOT_START_2K : // R4
    bflp_pkg::BOOT_START_4K; // R5

  // ---------------------------------------------------------------
  // address classification
  // ---------------------------------------------------------------
  wire [14:0] st_page_addr = {store_cmd.z[15:8], bflp_pkg::PAGE_BASE}; // R7
  wire st_in_boot = st_page_addr >= boundary; // R23
  wire st_in_blocked_during_write_region = st_page_addr >= bflp_pkg::BLOCKED_DURING_WRITE_REGION_START; // R6
  wire [14:0] ld_addr = load_z[15:1];
  wire ld_in_boot = ld_addr >= boundary; // R23
  wire ld_in_rww = ld_addr <= bflp_pkg::RWW_END; // R6
  wire pc_in_boot = fetch_pc >= boundary; // R23

  // ---------------------------------------------------------------
  // store checks
  // ---------------------------------------------------------------
  wire is_busy = state_reg == bflp_pkg::ST_BUSY;
  wire op_flash = (store_cmd.op == bflp_pkg::OP_ERASE) ||
                  (store_cmd.op == bflp_pkg::OP_WRITE);
  wire bad_byte = store_cmd.z[0]; // R9
  wire bad_word = (store_cmd.op == bflp_pkg::OP_WRITE) &&
                  (store_cmd.z[7:1] != 7'h00); // R8
  wire app_st_block = !st_in_boot && !app_lo; // R14 R15
  wire boot_st_block = st_in_boot && !boot_lo; // R18 R19
  wire st_deny = is_busy || bad_byte || bad_word ||
                 (op_flash && (app_st_block || boot_st_block));
  wire st_take = store_req && !st_deny;
  wire st_timed = st_take && (store_cmd.op != bflp_pkg::OP_FILL); // R1

  // ---------------------------------------------------------------
  // load checks
  // ---------------------------------------------------------------
  wire ld_app_block = pc_in_boot && !ld_in_boot && !app_hi; // R15 R16
  wire ld_boot_block = !pc_in_boot && ld_in_boot && !boot_hi; // R19 R20
  // the readable region is off limits while an erase or page write runs, not during a lock write
  wire ld_rww_block = is_busy && rww_busy_o && ld_in_rww; // R6
  wire ld_deny = ld_app_block || ld_boot_block || ld_rww_block;
  // interrupt suppression by vector placement
  wire irq_app_mute = ivec_in_boot && !pc_in_boot && !app_hi; // R17
  wire irq_boot_mute = !ivec_in_boot && pc_in_boot && !boot_hi; // R21
  // write timer: last tick of the programmed count
  wire tick_last = is_busy && rc_tick && (tick_reg == WR_TICKS - 13'h0001);
  wire spm_lock_end = tick_last && (spm_mask_reg != 6'h00);

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_hit = wb_req && !wb_ack_o;
  wire wb_wr = wb_req && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire sel_lock = wb_adr_i == bflp_pkg::OFS_LOCK;
  wire sel_fuse = wb_adr_i == bflp_pkg::OFS_FUSE;
  wire sel_ctrl = wb_adr_i == bflp_pkg::OFS_CTRL;
  wire sel_stat = wb_adr_i == bflp_pkg::OFS_STAT;
  wire wr_ctrl = wb_wr && sel_ctrl;
  wire chip_erase = wr_ctrl && wb_dat_i[bflp_pkg::CTRL_ERASE];
  wire clr_st = wr_ctrl && wb_dat_i[bflp_pkg::CTRL_CLR_ST];
  wire clr_ld = wr_ctrl && wb_dat_i[bflp_pkg::CTRL_CLR_LD];
  // fuses freeze once a memory lock bit is programmed
  wire fuse_open = mem_lo && mem_hi; // R12 R13 R22
  wire wr_fuse = wb_wr && sel_fuse && fuse_open;
  // an external lock write can only program bits, never erase them
  wire [5:0] wb_mask = (wb_wr && sel_lock) ? ~wb_dat_i[5:0] : 6'h00;
  wire [5:0] spm_mask = spm_lock_end ? spm_mask_reg : 6'h00;
  wire [31:0] stat_word = {26'h0000000, ld_denied_reg, st_denied_reg,
                           irq_suppress_o, cpu_halt_o, rww_busy_o, busy_o};
  wire [31:0] rd_word =
    sel_lock ? {24'h000000, lock_byte} :
    sel_fuse ? {30'h00000000, bootsz_reg} :
    sel_stat ? stat_word :
    32'h00000000;

  // ---------------------------------------------------------------
  // lock bits, one flop per bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < bflp_pkg::LK_BITS; gi++) begin : g_lock
      always_ff @(posedge clock) begin
        if (srst) begin
          lock_reg[gi] <= bflp_pkg::LOCK_RESET[gi];
        end else if (ce) begin
          if (chip_erase) begin
            lock_reg[gi] <= 1'b1; // R10
          end else begin
            lock_reg[gi] <= lock_reg[gi] & ~(wb_mask[gi] | spm_mask[gi]); // R10
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, write at ack
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= wb_hit;
      if (wb_hit) begin
        wb_dat_o <= rd_word;
      end
    end
  end
  // boot size fuse, held while the memory lock is set
  always_ff @(posedge clock) begin
    if (srst) begin
      bootsz_reg <= bflp_pkg::BOOTSZ_RESET;
    end else if (ce && wr_fuse) begin
      bootsz_reg <= wb_dat_i[1:0];
    end
  end

  // ---------------------------------------------------------------
  // write sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= bflp_pkg::ST_IDLE;
      tick_reg <= 13'h0000;
      spm_mask_reg <= 6'h00;
    end else if (ce) begin
      case (state_reg)
        bflp_pkg::ST_IDLE: begin
          if (st_timed) begin
            state_reg <= bflp_pkg::ST_BUSY; // R1
            tick_reg <= 13'h0000;
            // only the section lock bits are reachable from software
            spm_mask_reg <= (store_cmd.op == bflp_pkg::OP_LOCK) ?
                            (~{store_cmd.data[5:0]} & bflp_pkg::SPM_LOCK_MASK) : 6'h00;
          end
        end
        bflp_pkg::ST_BUSY: begin
          if (tick_last) begin
            state_reg <= bflp_pkg::ST_IDLE; // R1
            spm_mask_reg <= 6'h00;
          end else if (rc_tick) begin
            tick_reg <= tick_reg + 13'h0001; // R1
          end
        end
        default: begin
          state_reg <= bflp_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // progress outputs follow the sequencer edge for edge
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_o <= 1'b0;
      rww_busy_o <= 1'b0;
      cpu_halt_o <= 1'b0;
    end else if (ce) begin
      if (!is_busy && st_timed) begin
        busy_o <= 1'b1;
        rww_busy_o <= op_flash; // R6
        cpu_halt_o <= op_flash && st_in_blocked_during_write_region; // R6
      end else if (tick_last) begin
        busy_o <= 1'b0;
        rww_busy_o <= 1'b0;
        cpu_halt_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // store and load answers, one-cycle pulses plus held fields
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      store_done_o <= 1'b0;
      store_deny_o <= 1'b0;
      page_num_o <= 8'h00;
      word_idx_o <= 7'h00;
    end else if (ce) begin
      store_done_o <= st_take;
      store_deny_o <= store_req && st_deny; // R14 R18
      if (st_take) begin
        page_num_o <= store_cmd.z[15:8]; // R7
        word_idx_o <= store_cmd.z[7:1]; // R8
      end
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      load_ok_o <= 1'b0;
      load_deny_o <= 1'b0;
      load_word_o <= 15'h0000;
      load_byte_hi_o <= 1'b0;
    end else if (ce) begin
      load_ok_o <= load_req && !ld_deny;
      load_deny_o <= load_req && ld_deny; // R16 R20
      if (load_req) begin
        load_word_o <= ld_addr;
        load_byte_hi_o <= load_z[0]; // R9
      end
    end
  end
  // sticky denial flags; a new denial beats a software clear
  always_ff @(posedge clock) begin
    if (srst) begin
      st_denied_reg <= 1'b0;
      ld_denied_reg <= 1'b0;
    end else if (ce) begin
      st_denied_reg <= (store_req && st_deny) || (st_denied_reg && !clr_st);
      ld_denied_reg <= (load_req && ld_deny) || (ld_denied_reg && !clr_ld);
    end
  end

  // ---------------------------------------------------------------
  // context and external gates
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_suppress_o <= 1'b0;
      boot_vector_o <= bflp_pkg::BOOT_START_4K;
      ext_prog_en_o <= 1'b1;
      ext_verify_en_o <= 1'b1;
      fuse_wr_en_o <= 1'b1;
    end else if (ce) begin
      irq_suppress_o <= irq_app_mute || irq_boot_mute; // R17 R21
      boot_vector_o <= boundary; // R2 R3
      ext_prog_en_o <= mem_lo; // R12 R13
      ext_verify_en_o <= mem_lo || mem_hi; // R13
      fuse_wr_en_o <= fuse_open; // R12 R13
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [12:0] hlp_ticks;
  always_ff @(posedge clock) begin
    if (srst || !busy_o) begin
      hlp_ticks <= 13'h0000;
    end else if (ce && rc_tick) begin
      hlp_ticks <= hlp_ticks + 13'h0001;
    end
  end
  chk_write_time: assert property ( // R1
    @(posedge clock) disable iff (srst)
    $fell(busy_o) |-> hlp_ticks == WR_TICKS)
    else $error("flash write did not last the set tick count");
  chk_boot_map: assert property ( // R2 R3 R4 R5
    @(posedge clock) disable iff (srst || !ce)
    ##1 ce |-> boot_vector_o == (($past(bootsz_reg) == 2'h3) ? bflp_pkg::BOOT_START_512 :
      ($past(bootsz_reg) == 2'h2) ? bflp_pkg::BOOT_START_1K : ($past(bootsz_reg) == 2'h1) ?
      bflp_pkg::APP_END_2K + 15'h0001 : bflp_pkg::APP_END_4K + 15'h0001))
    else $error("boot vector does not match size select");
  chk_rww_block: assert property ( // R6
    @(posedge clock) disable iff (srst || !ce)
    load_req && rww_busy_o && load_z[15:1] <= bflp_pkg::RWW_END
    |=> load_deny_o && !load_ok_o)
    else $error("readable region load allowed during write");
  chk_page_field: assert property ( // R7
    @(posedge clock) disable iff (srst || !ce)
    store_req ##1 store_done_o |-> page_num_o == $past(store_cmd.z[15:8]))
    else $error("page number not taken from pointer bits");
  chk_word_zero: assert property ( // R8 R9
    @(posedge clock) disable iff (srst || !ce)
    store_req && (store_cmd.z[0] ||
      (store_cmd.op == bflp_pkg::OP_WRITE && store_cmd.z[7:1] != 7'h00))
    |=> store_deny_o ##1 !store_done_o)
    else $error("malformed store pointer accepted");
  chk_byte_sel: assert property ( // R9
    @(posedge clock) disable iff (srst || !ce)
    load_req |=> load_byte_hi_o == $past(load_z[0]) &&
                 (load_ok_o != load_deny_o))
    else $error("load byte select or answer wrong");
  chk_lock_only_clr: assert property ( // R10
    @(posedge clock) disable iff (srst || !ce)
    !chip_erase |=> (lock_reg & ~$past(lock_reg)) == 6'h00)
    else $error("lock bit returned to one without erase");
  chk_ext_gates: assert property ( // R12 R13
    @(posedge clock) disable iff (srst || !ce)
    !mem_lo |=> !ext_prog_en_o && !fuse_wr_en_o &&
                (ext_verify_en_o == $past(mem_hi)))
    else $error("external programming open under memory lock");
  chk_app_store: assert property ( // R14 R15
    @(posedge clock) disable iff (srst || !ce)
    store_req && op_flash && !st_in_boot && !app_lo
    |=> store_deny_o && !store_done_o)
    else $error("store to locked application section accepted");
  chk_boot_store: assert property ( // R18 R19
    @(posedge clock) disable iff (srst || !ce)
    store_req && op_flash && st_in_boot && !boot_lo
    |=> store_deny_o && !store_done_o)
    else $error("store to locked boot section accepted");
  chk_cross_load: assert property ( // R15 R16 R19 R20
    @(posedge clock) disable iff (srst || !ce)
    load_req && (pc_in_boot != ld_in_boot) &&
    !(pc_in_boot ? app_hi : boot_hi) |=> load_deny_o)
    else $error("cross-section load allowed under lock");
  chk_irq_mute: assert property ( // R17 R21
    @(posedge clock) disable iff (srst || !ce)
    (ivec_in_boot != pc_in_boot) &&
    !(ivec_in_boot ? app_hi : boot_hi) |=> irq_suppress_o)
    else $error("interrupts not suppressed in locked mode");
endmodule : bflp_top

//--- bflp_cpu_model.sv
// cpu core model: self-program stores, program memory loads, fetch context
module bflp_cpu_model (
  // clock
  input wire logic clock,
  // self-program stores
  output logic store_req,
  output bflp_pkg::bflp_store_t store_cmd,
  input wire logic store_done_o,
  input wire logic store_deny_o,
  // program memory loads
  output logic load_req,
  output logic [15:0] load_z,
  input wire logic load_ok_o,
  input wire logic load_deny_o,
  // execution context
  output logic [14:0] fetch_pc,
  output logic ivec_in_boot
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle core: nothing requested, running from address zero
  initial begin
    store_req = 1'b0;
    store_cmd = '0;
    load_req = 1'b0;
    load_z = 16'h0000;
    fetch_pc = 15'h0000;
    ivec_in_boot = 1'b0;
  end

  // one store pulse; the answer lands one edge later and is read at the next
  task automatic store(input bflp_pkg::bflp_op_t op, input logic [15:0] z, input logic [7:0] d,
                       output logic [1:0] res);
    @(posedge clock);
    store_req <= 1'b1;
    store_cmd <= {op, z, d};
    @(posedge clock);
    store_req <= 1'b0;
    // a released pointer never keeps its old value
    store_cmd <= bflp_pkg::bflp_store_t'(~store_cmd);
    @(posedge clock);
    res = {store_done_o, store_deny_o};
  endtask : store

  // one load pulse; bit 0 of the pointer picks the byte
  task automatic load(input logic [15:0] z, output logic [1:0] res);
    @(posedge clock);
    load_req <= 1'b1;
    load_z <= z;
    @(posedge clock);
    load_req <= 1'b0;
    load_z <= ~z;
    @(posedge clock);
    res = {load_ok_o, load_deny_o};
  endtask : load

  // move the fetch point and the vector table
  task automatic set_ctx(input logic [14:0] pc, input logic ivb);
    @(posedge clock);
    fetch_pc <= pc;
    ivec_in_boot <= ivb;
  endtask : set_ctx
endmodule : bflp_cpu_model

//--- bflp_top_tb.sv
// self-checking bench for the boot flash lock protection block
module bflp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // clock, rc tick, design and core model
  // ---------------------------------------------------------------
  localparam logic [12:0] WT = 13'h0004;
  localparam int TG = 5; // cycles between rc ticks, keeps timed writes short
  localparam logic [7:0] A_LK = bflp_pkg::OFS_LOCK;
  localparam logic [7:0] A_FU = bflp_pkg::OFS_FUSE;
  localparam logic [7:0] A_CT = bflp_pkg::OFS_CTRL;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic rc_tick = 1'b0;
  logic [31:0] wb_dat_o, r;
  logic [7:0] page_num_o;
  logic [6:0] word_idx_o;
  logic [14:0] load_word_o, boot_vector_o, fetch_pc;
  logic [15:0] load_z;
  logic [1:0] s;
  bflp_pkg::bflp_store_t store_cmd;
  logic wb_ack_o, store_req, store_done_o, store_deny_o, load_req, load_ok_o, load_deny_o;
  logic load_byte_hi_o, ivec_in_boot, irq_suppress_o, busy_o, rww_busy_o, cpu_halt_o;
  logic ext_prog_en_o, ext_verify_en_o, fuse_wr_en_o;
  int tcnt = 0;
  int n;
  int err_total = 0;
  int check_count = 0;
  // mode table: lock byte, boot-side row, expected store, load and irq results
  logic [7:0] lk [6] = '{8'hF3, 8'hF7, 8'hFB, 8'hCF, 8'hDF, 8'hEF};
  logic [1:0] se [6] = '{2'b01, 2'b10, 2'b01, 2'b01, 2'b10, 2'b01};
  logic [1:0] le [6] = '{2'b01, 2'b01, 2'b10, 2'b01, 2'b01, 2'b10};
  logic [5:0] bm = 6'b111000;
  logic [5:0] ie = 6'b011011;
  logic [14:0] bv [4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};

  always #5 clock = ~clock;

  // free-running tick, unrelated to when writes start
  always @(posedge clock) begin
    tcnt <= (tcnt == TG - 1) ? 0 : tcnt + 1;
    rc_tick <= (tcnt == TG - 1);
  end

  bflp_top #(.WR_TICKS(WT)) dut (.clock, .srst, .ce(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rc_tick, .store_req, .store_cmd,
    .store_done_o, .store_deny_o, .page_num_o, .word_idx_o, .load_req, .load_z, .load_ok_o,
    .load_deny_o, .load_word_o, .load_byte_hi_o, .fetch_pc, .ivec_in_boot, .irq_suppress_o,
    .boot_vector_o, .busy_o, .rww_busy_o, .cpu_halt_o, .ext_prog_en_o, .ext_verify_en_o,
    .fuse_wr_en_o);

  bflp_cpu_model cpu (.clock, .store_req, .store_cmd, .store_done_o, .store_deny_o, .load_req,
    .load_z, .load_ok_o, .load_deny_o, .fetch_pc, .ivec_in_boot);

  // ---------------------------------------------------------------
  // report, compare and bus tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  // done/deny pair of one store or ok/deny pair of one load
  task automatic chk_res(input string nm, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_res

  // classic single wishbone cycle, held until ack is sampled high
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int k;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      wrap_up();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_io

  // bounded wait for the timed write to finish; n counts the cycles
  task automatic wait_idle();
    n = 0;
    while (busy_o !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      wrap_up();
    end
  endtask : wait_idle

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    wb_io(1'b0, A_LK, 32'h0);
    chk_val("lock byte", 32'h0000_00FF, r);
    chk_val("boot vector", 32'h0000_7000, 32'(boot_vector_o));
    chk_val("ext gates", 32'h7, {29'h0, ext_prog_en_o, ext_verify_en_o, fuse_wr_en_o});
    $display("test reset finished");
    // fuses go in before any lock bit, every boot size in turn
    for (int i = 0; i < 4; i++) begin
      wb_io(1'b1, A_FU, 32'(i));
      repeat (2) @(posedge clock);
      chk_val("boot vector", 32'(bv[i]), 32'(boot_vector_o));
    end
    $display("test boot size finished");
    cpu.store(bflp_pkg::OP_FILL, 16'h0106, 8'h5A, s);
    chk_res("fill", 2'b10, s);
    chk_val("page word", 32'h0000_0103, {16'h0, page_num_o, 1'b0, word_idx_o});
    cpu.store(bflp_pkg::OP_FILL, 16'h0107, 8'h5A, s);
    chk_res("odd store", 2'b01, s);
    cpu.store(bflp_pkg::OP_WRITE, 16'h0102, 8'h00, s);
    chk_res("write with word", 2'b01, s);
    wb_io(1'b0, bflp_pkg::OFS_STAT, 32'h0);
    chk_val("store denied flag", 32'h10, r);
    wb_io(1'b1, A_CT, 32'h2);
    wb_io(1'b0, bflp_pkg::OFS_STAT, 32'h0);
    chk_val("store denied clear", 32'h0, r);
    cpu.load(16'h0103, s);
    chk_res("load", 2'b10, s);
    chk_val("load pointer", 32'h0000_0103, {16'h0, load_word_o, load_byte_hi_o});
    $display("test pointer finished");
    cpu.store(bflp_pkg::OP_ERASE, 16'h0100, 8'h00, s);
    chk_res("erase app", 2'b10, s);
    chk_val("busy flags", 32'h6, {29'h0, busy_o, rww_busy_o, cpu_halt_o});
    cpu.load(16'h0100, s);
    chk_res("load rww busy", 2'b01, s);
    cpu.load(16'hE000, s);
    chk_res("load blocked_during_write_region busy", 2'b10, s);
    wait_idle();
    chk_val("write time", 32'h1, 32'(n + 6 >= 14 && n + 6 <= 22));
    cpu.store(bflp_pkg::OP_ERASE, 16'hFC00, 8'h00, s);
    chk_res("erase boot", 2'b10, s);
    chk_val("busy flags", 32'h7, {29'h0, busy_o, rww_busy_o, cpu_halt_o});
    wait_idle();
    // lock write by store leaves the memory lock bits alone
    cpu.store(bflp_pkg::OP_LOCK, 16'h0000, 8'hF8, s);
    chk_res("lock store", 2'b10, s);
    wait_idle();
    wb_io(1'b0, A_LK, 32'h0);
    chk_val("lock byte", 32'h0000_00FB, r);
    wb_io(1'b1, A_LK, 32'hFF);
    wb_io(1'b0, A_LK, 32'h0);
    chk_val("lock byte", 32'h0000_00FB, r);
    $display("test timed write finished");
    // each section lock mode; boundary addresses on both sides
    for (int i = 0; i < 6; i++) begin
      wb_io(1'b1, A_CT, 32'h1);
      wb_io(1'b1, A_LK, 32'(lk[i]));
      wb_io(1'b0, A_LK, 32'h0);
      chk_val("lock byte", 32'(lk[i]), r);
      cpu.store(bflp_pkg::OP_ERASE, bm[i] ? 16'hFC00 : 16'h0100, 8'h00, s);
      chk_res("locked erase", se[i], s);
      wait_idle();
      cpu.set_ctx(bm[i] ? 15'h7DFF : 15'h7E00, ~bm[i]);
      cpu.load(bm[i] ? 16'hFC00 : 16'hFBFE, s);
      chk_res("locked load", le[i], s);
      cpu.set_ctx(bm[i] ? 15'h7E00 : 15'h7DFF, ~bm[i]);
      repeat (3) @(posedge clock);
      chk_val("irq mute", 32'(ie[i]), 32'(irq_suppress_o));
    end
    $display("test lock modes finished");
    wb_io(1'b1, A_LK, 32'hFE);
    repeat (2) @(posedge clock);
    chk_val("ext gates", 32'h2, {29'h0, ext_prog_en_o, ext_verify_en_o, fuse_wr_en_o});
    wb_io(1'b1, A_FU, 32'h0);
    repeat (2) @(posedge clock);
    chk_val("boot vector", 32'h0000_7E00, 32'(boot_vector_o));
    wb_io(1'b1, A_LK, 32'hFC);
    repeat (2) @(posedge clock);
    chk_val("ext gates", 32'h0, {29'h0, ext_prog_en_o, ext_verify_en_o, fuse_wr_en_o});
    wb_io(1'b1, A_CT, 32'h1);
    wb_io(1'b0, A_LK, 32'h0);
    chk_val("lock byte", 32'h0000_00FF, r);
    chk_val("ext gates", 32'h7, {29'h0, ext_prog_en_o, ext_verify_en_o, fuse_wr_en_o});
    $display("test memory lock finished");
    wrap_up();
  end
endmodule : bflp_top_tb
